// ===== dv/asu_remote.sv
// Remote serial station: sends frames on the receive line, captures transmitted frames
`timescale 1ns/10ps
module asu_remote
(
    input  wire logic clk_i,
    input  wire logic txd_i,
    output logic      rxd_o
);
    int          bit_clks = 16;
    int          cap_n    = 10;
    logic [11:0] got_q[$];

    initial rxd_o = 1'b1;

    task automatic send(input logic [11:0] fr, input int n);
        for (int i = 0; i < n; i++)
        begin
            rxd_o <= fr[i];
            repeat (bit_clks) @(posedge clk_i);
        end
        // Pull-up level once the frame ends
        rxd_o <= 1'b1;
    endtask

    // Capture mid-bit, timed from the start edge
    initial forever
    begin
        logic [11:0] f;
        @(negedge txd_i);
        f = '1;
        repeat (bit_clks / 2) @(posedge clk_i);
        for (int i = 0; i < cap_n; i++)
        begin
            f[i] = txd_i;
            if (i < cap_n - 1)
                repeat (bit_clks) @(posedge clk_i);
        end
        got_q.push_back(f);
    end
endmodule

// ===== dv/asu_uart_tb.sv
// Self-checking bench of the async serial unit against a frame model
`timescale 1ns/10ps
module asu_uart_tb;
    import asu_pkg::*;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc   = 1'b0;
    logic        stb   = 1'b0;
    logic        we    = 1'b0;
    logic [5:0]  adr   = '0;
    logic [31:0] wdat  = '0;
    logic [31:0] rdat;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o, rxd, txd_o, txe_irq, rxf_irq, rxe_irq, irq_o;
    int          err_count = 0;
    int          cmp_count = 0;
    int          seed      = 93242;
    int          n, nr;
    logic [7:0]  d, e;
    logic [5:0]  m;
    logic [11:0] f, ftx;
    logic [5:0]  modes [4] = '{6'h00, 6'h03, 6'h16, 6'h28};

    always #12.5 clk_i = ~clk_i;

    asu_uart i_asu_uart (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .rxd_i(rxd), .txd_o(txd_o), .tx_empty_irq_o(txe_irq), .rx_full_irq_o(rxf_irq),
        .rx_fault_irq_o(rxe_irq), .irq_o(irq_o));
    asu_remote i_asu_remote (.clk_i(clk_i), .txd_i(txd_o), .rxd_o(rxd));

    // ****
    // Tasks
    // ****
    task automatic stop_test();
        if (err_count == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        cmp_count++;
        if (got !== ex)
        begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", nm, ex, got);
        end
    endtask

    task automatic tmo(input logic ok);
        if (!ok)
        begin
            err_count++;
            $display("[ERR] wait expected 1 seen 0");
            stop_test();
        end
    endtask

    // Classic cycle: hold until ack is sampled, then release for a cycle
    task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] v);
        int k;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= v;
        k = 0;
        do
        begin
            @(posedge clk_i);
            k++;
        end
        while (wb_ack_o !== 1'b1 && k < 20);
        tmo(wb_ack_o === 1'b1);
        rdat = wb_dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_i);
    endtask

    function automatic logic sig(input int s);
        case (s)
            0: return txe_irq;
            1: return rxf_irq;
            2: return rxe_irq;
            default: return logic'(i_asu_remote.got_q.size() > 0);
        endcase
    endfunction

    task automatic wfor(input int s);
        for (int k = 0; k < 1000 && sig(s) !== 1'b1; k++)
            @(posedge clk_i);
        tmo(sig(s) === 1'b1);
    endtask

    // Expected line bits of one character, start bit first
    function automatic logic [11:0] mk(input logic [7:0] v, input logic [5:0] md, output int cnt);
        logic [11:0] r;
        logic        p;
        int          nb;
        r = '1;
        r[0] = 1'b0;
        nb = md[0] ? 7 : 8;
        p = md[2];
        for (int k = 0; k < nb; k++)
        begin
            r[k + 1] = v[k];
            p = p ^ v[k];
        end
        cnt = nb + 1;
        if (md[1] || md[3])
        begin
            r[cnt] = md[1] ? p : md[5];
            cnt++;
        end
        cnt = cnt + (md[4] ? 2 : 1);
        return r;
    endfunction

    // ****
    // Main sequence
    // ****
    initial
    begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        bus(1'b0, 6'h00, 32'h0);
        chk("ctrl reset", 32'h00, rdat);
        bus(1'b0, 6'h04, 32'h0);
        chk("flags reset", 32'h80, rdat);
        bus(1'b1, 6'h00, 32'hFF);
        bus(1'b0, 6'h00, 32'h0);
        chk("ctrl rw", 32'hFC, rdat);
        bus(1'b0, 6'h20, 32'h0);
        chk("unmapped", 32'h00, rdat);
        bus(1'b1, 6'h14, 32'h0);
        bus(1'b1, 6'h1C, 32'h7);
        foreach (modes[i])
        begin
            m = modes[i];
            d = 8'($random(seed));
            e = 8'($random(seed));
            f = mk(e, m, nr);
            ftx = mk(d, m, n);
            i_asu_remote.cap_n = n;
            bus(1'b1, 6'h10, {26'h0, m});
            bus(1'b1, 6'h00, 32'hF0);
            fork
                i_asu_remote.send(f, nr);
                begin
                    bus(1'b1, 6'h08, {24'h0, d});
                    bus(1'b0, 6'h04, 32'h0);
                    bus(1'b1, 6'h04, 32'h0);
                    wfor(0);
                    chk("tx empty irq", 1, txe_irq);
                    bus(1'b1, 6'h00, 32'h70);
                    chk("tx irq off", 0, txe_irq);
                end
            join
            wfor(3);
            chk("tx frame", ftx, i_asu_remote.got_q.pop_front());
            wfor(1);
            bus(1'b0, 6'h0C, 32'h0);
            chk("rx data", m[0] ? e & 8'h7F : e, rdat);
            chk("irq", 1, irq_o);
            bus(1'b0, 6'h18, 32'h0);
            chk("status", 32'h3, rdat);
            chk("irq cleared", 0, irq_o);
            bus(1'b0, 6'h04, 32'h0);
            chk("rx flags", {24'h0, 8'hC0 | (m[3] ? {6'h0, m[5], 1'b0} : 8'h00)}, rdat);
            // Keep bit 7 set so no stale character is launched
            bus(1'b1, 6'h04, 32'h80);
            chk("rx irq off", 0, rxf_irq);
        end
        bus(1'b1, 6'h10, 32'h0);
        f = mk(e, 6'h00, nr);
        f[9] = 1'b0;
        i_asu_remote.send(f, 10);
        wfor(2);
        bus(1'b0, 6'h04, 32'h0);
        // Received multiprocessor bit is sticky since the mp-mode pass
        chk("frame flags", 32'hD2, rdat);
        bus(1'b1, 6'h04, 32'h80);
        chk("fault irq off", 0, rxe_irq);
        // Two bad-parity characters: the second one overruns the full holding register
        bus(1'b1, 6'h10, 32'h02);
        f = mk(e, 6'h02, nr);
        f[9] = ~f[9];
        i_asu_remote.send(f, nr);
        @(posedge clk_i);
        ftx = mk(d, 6'h02, n);
        ftx[9] = ~ftx[9];
        i_asu_remote.send(ftx, n);
        wfor(2);
        bus(1'b0, 6'h0C, 32'h0);
        chk("overrun data", e, rdat);
        bus(1'b0, 6'h04, 32'h0);
        chk("fault flags", 32'hEA, rdat);
        stop_test();
    end
endmodule

// ===== hw/asu_baud16.sv
// Oversampling tick generator, restartable to align to a line edge
`timescale 1ns/10ps
module asu_baud16
    import asu_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        restart_i,
    input  wire logic [15:0] div_i,
    output logic             tick_o
);
    logic [15:0] cnt_q;
    logic        tick_q;

    always_ff @(posedge clk_i)
    begin
        if (rst_i || restart_i)
        begin
            cnt_q  <= 16'h0000;
            tick_q <= 1'b0;
        end
        else if (cnt_q >= div_i)
        begin
            cnt_q  <= 16'h0000;
            tick_q <= 1'b1;
        end
        else
        begin
            cnt_q  <= cnt_q + 16'h0001;
            tick_q <= 1'b0;
        end
    end

    assign tick_o = tick_q;
endmodule

// ===== hw/asu_pkg.sv
// Constants, types and register map of the async serial unit
package asu_pkg;

    // ************************************************************
    // Register map (word indices, taken from bus address bits 5:2)
    // ************************************************************
    localparam logic [3:0] IDX_CTRL  = 4'h0;
    localparam logic [3:0] IDX_FLAGS = 4'h1;
    localparam logic [3:0] IDX_TXH   = 4'h2;
    localparam logic [3:0] IDX_RXH   = 4'h3;
    localparam logic [3:0] IDX_MODE  = 4'h4;
    localparam logic [3:0] IDX_DIV   = 4'h5;
    localparam logic [3:0] IDX_STS   = 4'h6;
    localparam logic [3:0] IDX_MASK  = 4'h7;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int CTRL_TX_IRQ_EN  = 7;
    localparam int CTRL_RX_IRQ_EN  = 6;
    localparam int CTRL_TX_ON      = 5;
    localparam int CTRL_RX_ON      = 4;
    localparam int FLG_TX_EMPTY    = 7;
    localparam int FLG_RX_FULL     = 6;
    localparam int FLG_OVERRUN     = 5;
    localparam int FLG_FRAMING     = 4;
    localparam int FLG_PARITY      = 3;
    localparam int FLG_MP_BIT      = 1;
    localparam int STS_TX_EMPTY    = 0;
    localparam int STS_RX_FULL     = 1;
    localparam int STS_RX_FAULT    = 2;

    // ************************************************************
    // Reset values and masks
    // ************************************************************
    localparam logic [7:0]  CTRL_RST   = 8'h00;
    localparam logic [7:0]  CTRL_WMASK = 8'hFC;
    localparam logic [7:0]  FLG_RST    = 8'h80;
    localparam logic [7:0]  FLG_CLR    = 8'hF8;
    localparam logic [5:0]  MODE_RST   = 6'h00;
    localparam logic [2:0]  STS_RST    = 3'h0;
    localparam logic [2:0]  MASK_RST   = 3'h0;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int          CLK_HZ      = 40_000_000;
    localparam int          BAUD_RST    = 9600;
    localparam int          OVERSAMPLE  = 16;
    localparam logic [15:0] DIV_RST     = 16'(CLK_HZ / (BAUD_RST * OVERSAMPLE) - 1);
    localparam logic [3:0]  SAMPLE_PH   = 4'h7;
    localparam logic [3:0]  LAST_PH     = 4'(OVERSAMPLE - 1);

    // ************************************************************
    // Types
    // ************************************************************
    typedef struct packed {
        logic mp_tx;
        logic two_stop;
        logic mp_mode;
        logic par_odd;
        logic par_en;
        logic char7;
    } asu_fmt_t;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_START = 3'b001,
        ST_DATA  = 3'b010,
        ST_PAR   = 3'b011,
        ST_STOP  = 3'b100
    } asu_bit_st_t;

    // Parity bit that makes the character even, or odd when asked
    function automatic logic asu_parity(input logic [7:0] d, input logic c7, input logic odd);
        asu_parity = (^(c7 ? {1'b0, d[6:0]} : d)) ^ odd;
    endfunction

endpackage

// ===== hw/asu_uart.sv
// Async serial unit: register slave, transmitter, receiver, interrupts
`timescale 1ns/10ps
module asu_uart
    import asu_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [5:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        rxd_i,
    output logic             txd_o,
    output logic             tx_empty_irq_o,
    output logic             rx_full_irq_o,
    output logic             rx_fault_irq_o,
    output logic             irq_o
);
    // ************************************************************
    // Bus slave
    // ************************************************************
    logic        ack_q;
    logic [31:0] dat_q;
    logic [31:0] rd_d;
    logic        acc;
    logic        wr;
    logic        rd;
    logic [3:0]  idx;
    logic        mapped;

    logic [7:0]  ctrl_q;
    logic [7:0]  flg_q;
    logic [7:0]  seen_q;
    logic [7:0]  txh_q;
    logic [7:0]  rxh_q;
    asu_fmt_t    fmt_q;
    logic [15:0] div_q;
    logic [2:0]  sts_q;
    logic [2:0]  mask_q;

    assign acc    = wb_cyc_i && wb_stb_i && !ack_q;
    assign wr     = acc && wb_we_i;
    assign rd     = acc && !wb_we_i;
    assign idx    = wb_adr_i[5:2];
    assign mapped = (idx <= IDX_MASK);

    always_comb
    begin
        rd_d = 32'h0000_0000;
        case (idx)
            IDX_CTRL:  rd_d[7:0]  = ctrl_q;
            IDX_FLAGS: rd_d[7:0]  = flg_q;
            IDX_TXH:   rd_d[7:0]  = txh_q;
            IDX_RXH:   rd_d[7:0]  = rxh_q;
            IDX_MODE:  rd_d[5:0]  = fmt_q;
            IDX_DIV:   rd_d[15:0] = div_q;
            IDX_STS:   rd_d[2:0]  = sts_q;
            IDX_MASK:  rd_d[2:0]  = mask_q;
            default:   rd_d       = 32'h0000_0000;
        endcase
    end

    // Unmapped addresses still answer, reading zero, so the bus never hangs
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_q <= 1'b0;
            dat_q <= 32'h0000_0000;
        end
        else
        begin
            ack_q <= acc;
            dat_q <= (rd && mapped) ? rd_d : 32'h0000_0000;
        end
    end

    // ************************************************************
    // Software registers
    // ************************************************************
    logic wr_byte0;
    assign wr_byte0 = wr && wb_sel_i[0];

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            ctrl_q <= CTRL_RST;
        else if (wr_byte0 && idx == IDX_CTRL)
            ctrl_q <= wb_dat_i[7:0] & CTRL_WMASK;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            txh_q  <= 8'h00;
            fmt_q  <= MODE_RST;
            mask_q <= MASK_RST;
        end
        else if (wr_byte0)
        begin
            if (idx == IDX_TXH)
                txh_q <= wb_dat_i[7:0];
            if (idx == IDX_MODE)
                fmt_q <= wb_dat_i[5:0];
            if (idx == IDX_MASK)
                mask_q <= wb_dat_i[2:0];
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            div_q <= DIV_RST;
        else if (wr && idx == IDX_DIV)
        begin
            if (wb_sel_i[0])
                div_q[7:0] <= wb_dat_i[7:0];
            if (wb_sel_i[1])
                div_q[15:8] <= wb_dat_i[15:8];
        end
    end

    // ************************************************************
    // Flags 7 to 3: cleared by reading 1 then writing 0; hardware set wins
    // ************************************************************
    logic [7:0] flg_set;
    logic [7:0] flg_clr;

    assign flg_clr = (wr_byte0 && idx == IDX_FLAGS) ? (seen_q & ~wb_dat_i[7:0] & FLG_CLR) : 8'h00;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            flg_q  <= FLG_RST;
            seen_q <= 8'h00;
        end
        else
        begin
            flg_q <= (flg_q & ~flg_clr) | flg_set;
            if (rd && idx == IDX_FLAGS)
                seen_q <= flg_q;
            else
                seen_q <= seen_q & ~flg_clr;
        end
    end

    // ************************************************************
    // Transmitter
    // ************************************************************
    asu_bit_st_t tx_st;
    logic [3:0]  tx_ph;
    logic [2:0]  tx_cnt;
    logic [7:0]  tx_sh;
    logic        tx_pbit;
    logic        tx_stop2;
    logic        txd_q;
    logic        tx_tick;
    logic        tx_load;
    logic        tx_end;
    logic [2:0]  last_bit;

    assign last_bit = fmt_q.char7 ? 3'h6 : 3'h7;
    // Load only on empty flag low, independent of receiver
    assign tx_load  = (tx_st == ST_IDLE) && ctrl_q[CTRL_TX_ON] && !flg_q[FLG_TX_EMPTY];
    assign tx_end   = tx_tick && (tx_ph == LAST_PH);

    asu_baud16 u_tx_baud (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .restart_i (tx_load),
        .div_i     (div_q),
        .tick_o    (tx_tick)
    );

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            tx_st    <= ST_IDLE;
            tx_ph    <= 4'h0;
            tx_cnt   <= 3'h0;
            tx_sh    <= 8'h00;
            tx_pbit  <= 1'b0;
            tx_stop2 <= 1'b0;
        end
        else
        begin
            if (tx_tick)
                tx_ph <= tx_ph + 4'h1;
            case (tx_st)
                ST_IDLE:
                begin
                    tx_ph <= 4'h0;
                    if (tx_load)
                    begin
                        tx_st   <= ST_START;
                        tx_sh   <= txh_q;
                        tx_pbit <= fmt_q.par_en ? asu_parity(txh_q, fmt_q.char7, fmt_q.par_odd) : fmt_q.mp_tx;
                    end
                end
                ST_START:
                    if (tx_end)
                    begin
                        tx_st  <= ST_DATA;
                        tx_cnt <= 3'h0;
                    end
                ST_DATA:
                    if (tx_end)
                    begin
                        tx_sh  <= {1'b0, tx_sh[7:1]};
                        tx_cnt <= tx_cnt + 3'h1;
                        if (tx_cnt == last_bit)
                        begin
                            tx_st    <= (fmt_q.par_en || fmt_q.mp_mode) ? ST_PAR : ST_STOP;
                            tx_stop2 <= 1'b0;
                        end
                    end
                ST_PAR:
                    if (tx_end)
                        tx_st <= ST_STOP;
                ST_STOP:
                    if (tx_end)
                    begin
                        if (fmt_q.two_stop && !tx_stop2)
                            tx_stop2 <= 1'b1;
                        else
                            tx_st <= ST_IDLE;
                    end
                default:
                    tx_st <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            txd_q <= 1'b1;
        else
        begin
            case (tx_st)
                ST_START: txd_q <= 1'b0;
                ST_DATA:  txd_q <= tx_sh[0];
                ST_PAR:   txd_q <= tx_pbit;
                default:  txd_q <= 1'b1;
            endcase
        end
    end

    // ************************************************************
    // Receiver
    // ************************************************************
    asu_bit_st_t rx_st;
    logic        rx_s1;
    logic        rx_s2;
    logic        rx_s3;
    logic [3:0]  rx_ph;
    logic [2:0]  rx_cnt;
    logic [7:0]  rx_sh;
    logic        rx_pbit;
    logic        rx_tick;
    logic        rx_edge;
    logic        rx_smp;
    logic        rx_done;
    logic [7:0]  rx_data;

    // Pin is asynchronous: two flops before anything looks at it
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            rx_s1 <= 1'b1;
            rx_s2 <= 1'b1;
            rx_s3 <= 1'b1;
        end
        else
        begin
            rx_s1 <= rxd_i;
            rx_s2 <= rx_s1;
            rx_s3 <= rx_s2;
        end
    end

    // Falling edge restarts the sampling clock
    assign rx_edge = (rx_st == ST_IDLE) && ctrl_q[CTRL_RX_ON] && rx_s3 && !rx_s2;
    // Sample on the eighth oversampling pulse
    assign rx_smp  = rx_tick && (rx_ph == SAMPLE_PH);
    assign rx_done = (rx_st == ST_STOP) && rx_smp;
    assign rx_data = fmt_q.char7 ? {1'b0, rx_sh[7:1]} : rx_sh;

    asu_baud16 u_rx_baud (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .restart_i (rx_edge),
        .div_i     (div_q),
        .tick_o    (rx_tick)
    );

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            rx_st   <= ST_IDLE;
            rx_ph   <= 4'h0;
            rx_cnt  <= 3'h0;
            rx_sh   <= 8'h00;
            rx_pbit <= 1'b0;
        end
        else if (!ctrl_q[CTRL_RX_ON])
            rx_st <= ST_IDLE;
        else
        begin
            if (rx_edge)
                rx_ph <= 4'h0;
            else if (rx_tick)
                rx_ph <= rx_ph + 4'h1;
            case (rx_st)
                ST_IDLE:
                    if (rx_edge)
                        rx_st <= ST_START;
                ST_START:
                    if (rx_smp)
                    begin
                        rx_st  <= rx_s2 ? ST_IDLE : ST_DATA;
                        rx_cnt <= 3'h0;
                    end
                ST_DATA:
                    if (rx_smp)
                    begin
                        rx_sh  <= {rx_s2, rx_sh[7:1]};
                        rx_cnt <= rx_cnt + 3'h1;
                        if (rx_cnt == last_bit)
                            rx_st <= (fmt_q.par_en || fmt_q.mp_mode) ? ST_PAR : ST_STOP;
                    end
                ST_PAR:
                    if (rx_smp)
                    begin
                        rx_pbit <= rx_s2;
                        rx_st   <= ST_STOP;
                    end
                ST_STOP:
                    if (rx_smp)
                        rx_st <= ST_IDLE;
                default:
                    rx_st <= ST_IDLE;
            endcase
        end
    end

    // Holding register takes the character unless still full
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            rxh_q <= 8'h00;
        else if (rx_done && !flg_q[FLG_RX_FULL])
            rxh_q <= rx_data;
    end

    // Loading the shifter empties the holding register
    always_comb
    begin
        flg_set = 8'h00;
        flg_set[FLG_TX_EMPTY] = tx_load;
        if (rx_done)
        begin
            flg_set[FLG_RX_FULL] = !flg_q[FLG_RX_FULL];
            flg_set[FLG_OVERRUN] = flg_q[FLG_RX_FULL];
            flg_set[FLG_FRAMING] = !rx_s2;
            flg_set[FLG_PARITY]  = fmt_q.par_en && (rx_pbit != asu_parity(rx_data, fmt_q.char7, fmt_q.par_odd));
            flg_set[FLG_MP_BIT]  = fmt_q.mp_mode && rx_pbit;
        end
    end

    // ************************************************************
    // Interrupts
    // ************************************************************
    logic [2:0] sts_ev;
    logic       tx_irq_q;
    logic       rxf_irq_q;
    logic       rxe_irq_q;
    logic       irq_q;
    logic       rx_err;

    assign rx_err = flg_q[FLG_OVERRUN] || flg_q[FLG_FRAMING] || flg_q[FLG_PARITY];
    assign sts_ev = {|flg_set[FLG_OVERRUN:FLG_PARITY], flg_set[FLG_RX_FULL], tx_load};

    // Read clears the sticky bits, but an event in the same cycle survives
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            sts_q <= STS_RST;
        else
            sts_q <= ((rd && idx == IDX_STS) ? STS_RST : sts_q) | sts_ev;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            tx_irq_q  <= 1'b0;
            rxf_irq_q <= 1'b0;
            rxe_irq_q <= 1'b0;
            irq_q     <= 1'b0;
        end
        else
        begin
            tx_irq_q  <= ctrl_q[CTRL_TX_IRQ_EN] && flg_q[FLG_TX_EMPTY];
            rxf_irq_q <= ctrl_q[CTRL_RX_IRQ_EN] && flg_q[FLG_RX_FULL];
            rxe_irq_q <= ctrl_q[CTRL_RX_IRQ_EN] && rx_err;
            irq_q     <= |(sts_q & mask_q);
        end
    end

    assign wb_ack_o       = ack_q;
    assign wb_dat_o       = dat_q;
    assign txd_o          = txd_q;
    assign tx_empty_irq_o = tx_irq_q;
    assign rx_full_irq_o  = rxf_irq_q;
    assign rx_fault_irq_o = rxe_irq_q;
    assign irq_o          = irq_q;

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    chk_ctrl_low_zero: assert property (ctrl_q[1:0] == 2'b00)
        else $error("control low bits not zero");
    chk_ctrl_reset: assert property ($fell(rst_i) |-> ctrl_q == CTRL_RST)
        else $error("control not zero after reset");
    chk_tx_load: assert property (tx_load |=> flg_q[FLG_TX_EMPTY] && tx_st == ST_START)
        else $error("load did not set empty flag");
    chk_start_low: assert property (tx_load |=> ##1 !txd_q)
        else $error("start bit not low");
    chk_idle_high: assert property (tx_st == ST_IDLE && !tx_load |=> txd_q)
        else $error("idle line not high");
    chk_tx_irq: assert property (!ctrl_q[CTRL_TX_IRQ_EN] |=> !tx_empty_irq_o)
        else $error("transmit request not withdrawn");
    chk_rx_fault_irq: assert property (ctrl_q[CTRL_RX_IRQ_EN] && rx_err |=> rx_fault_irq_o)
        else $error("receive fault request missing");
    chk_false_start: assert property (
        rx_st == ST_START && rx_smp && rx_s2 && ctrl_q[CTRL_RX_ON] |=> rx_st == ST_IDLE)
        else $error("false start not dropped");
    chk_rx_holding: assert property (
        rx_done && !flg_q[FLG_RX_FULL] |=> flg_q[FLG_RX_FULL] && rxh_q == $past(rx_data))
        else $error("received character not held");
endmodule
